// File: logic/pdis_consts.svh
`ifndef PDIS_CONSTS_SVH
`define PDIS_CONSTS_SVH

// Register word offset on the bus
`define PDIS_CTRL1_OFS      12'h000
`define PDIS_ADDR_W         12

// Bit positions inside peripheral_disable_ctrl_1
`define PDIS_TIMER_LSB      11
`define PDIS_TIMER_MSB      15
`define PDIS_TWOWIRE1_BIT   7
`define PDIS_ASYNC2_BIT     6
`define PDIS_ASYNC1_BIT     5
`define PDIS_SYNC2_BIT      4
`define PDIS_SYNC1_BIT      3
`define PDIS_CAN1_BIT       1
`define PDIS_ADC1_BIT       0

// Byte lanes of the write data and their strobes
`define PDIS_LANE0_STRB     0
`define PDIS_LANE1_STRB     1
`define PDIS_LANE0_LSB      0
`define PDIS_LANE1_MSB      15

// Read data padding and the idle read value
`define PDIS_RD_PAD         16'h0000
`define PDIS_RD_IDLE        32'h00000000

// Implemented bits; 10..8 and 2 hold no storage
`define PDIS_CTRL1_MASK     16'hF8FB
`define PDIS_CTRL1_RESET    16'h0000

// Shared analog pin count and the all-digital pattern
`define PDIS_AN_PINS        32
`define PDIS_AN_ALL_DIGITAL 32'hFFFFFFFF

`endif

// File: logic/pdis_pkg.sv
`include "pdis_consts.svh"

package pdis_pkg;
  typedef logic [15:0]                    ctrl_word_t;
  typedef logic [`PDIS_ADDR_W-1:0]        apb_addr_t;
  typedef logic [`PDIS_AN_PINS-1:0]       an_cfg_t;
endpackage

// File: logic/peripheral_disable_low_bits.sv
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/100ps
// Function
// R1: Bits ten to eight store nothing, read zero, ignore writes.
// R2: Bit 7 set disables the first two-wire serial controller.
// R3: Bit 6 set disables the second asynchronous serial port.
// R4: Bit 5 set disables the first asynchronous serial port.
// R5: Bit 4 set disables the second synchronous serial port.
// R6: Bit 3 set disables the first synchronous serial port.
// R7: Converter disabled forces analog pin config ignored, all shared pins digital.
// R8: Each disable output follows its stored bit from the completing write edge.
`include "pdis_consts.svh"

module peripheral_disable_low_bits
  import pdis_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire apb_addr_t   paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Peripheral disables
  output logic             twowire1_disable,
  output logic             async_port2_disable,
  output logic             async_port1_disable,
  output logic             sync_port2_disable,
  output logic             sync_port1_disable,
  output logic [4:0]       timer_disable,
  output logic             can1_disable,
  output logic             adc1_disable,
  // Analog pin configuration, same clock domain
  input  wire an_cfg_t     analog_pin_config_bits,
  output an_cfg_t          analog_pin_digital
);

  localparam ctrl_word_t CTRL1_RESET = `PDIS_CTRL1_RESET;

  // Stored disable fields, one flop group per peripheral
  logic [4:0]  timer_dis_ff;
  logic        twowire1_ff;
  logic        async2_ff;
  logic        async1_ff;
  logic        sync2_ff;
  logic        sync1_ff;
  logic        can1_ff;
  logic        adc1_ff;

  // Bus response flops
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;

  // Pin override flop and its next value
  an_cfg_t     pin_digital_ff;
  an_cfg_t     nxt_pin_digital;

  // Decoded bus phases
  logic        setup_phase;
  logic        access_done;
  logic        hit;
  logic        rd_setup;
  logic        wr_fire;
  logic        wr_lane0;
  logic        wr_lane1;

  // Whole-word views of the register
  ctrl_word_t  cur_ctrl;
  ctrl_word_t  nxt_ctrl;

  // One mapped word; anything else answers with an error
  function automatic logic addr_hit(input apb_addr_t a);
    addr_hit = (a == `PDIS_CTRL1_OFS);
  endfunction

  // Holes hold no storage, so they are cleared going in and coming out
  function automatic ctrl_word_t mask_holes(input ctrl_word_t w);
    mask_holes = w & `PDIS_CTRL1_MASK;
  endfunction

  // Read word: upper half of the bus is always zero
  function automatic logic [31:0] read_word(input ctrl_word_t w);
    read_word = {`PDIS_RD_PAD, mask_holes(w)};
  endfunction

  // Setup cycle and the access cycle that completes it
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready_ff;
  assign hit         = addr_hit(paddr);
  assign rd_setup    = setup_phase & ~pwrite & hit;

  // A write lands only at the edge ending the access phase
  // Unmapped writes fall through here and change nothing
  assign wr_fire  = access_done & pwrite & hit;
  assign wr_lane0 = wr_fire & pstrb[`PDIS_LANE0_STRB];
  assign wr_lane1 = wr_fire & pstrb[`PDIS_LANE1_STRB];

  // Incoming word with the holes already cleared
  assign nxt_ctrl = mask_holes(pwdata[`PDIS_LANE1_MSB:`PDIS_LANE0_LSB]); // [R1]

  // Reassemble the stored fields for readback
  // Holes stay at the zero default, nothing drives them
  always_comb begin
    cur_ctrl                                  = '0;
    cur_ctrl[`PDIS_TIMER_MSB:`PDIS_TIMER_LSB] = timer_dis_ff;
    cur_ctrl[`PDIS_TWOWIRE1_BIT]              = twowire1_ff;
    cur_ctrl[`PDIS_ASYNC2_BIT]                = async2_ff;
    cur_ctrl[`PDIS_ASYNC1_BIT]                = async1_ff;
    cur_ctrl[`PDIS_SYNC2_BIT]                 = sync2_ff;
    cur_ctrl[`PDIS_SYNC1_BIT]                 = sync1_ff;
    cur_ctrl[`PDIS_CAN1_BIT]                  = can1_ff;
    cur_ctrl[`PDIS_ADC1_BIT]                  = adc1_ff;
  end

  // Timer disables sit in the upper byte lane
  // A low-lane-only write leaves them untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_dis_ff <= CTRL1_RESET[`PDIS_TIMER_MSB:`PDIS_TIMER_LSB];
    end else if (wr_lane1) begin
      timer_dis_ff <= nxt_ctrl[`PDIS_TIMER_MSB:`PDIS_TIMER_LSB];
    end
  end

  // Two-wire controller disable
  // Held until the next low-lane write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      twowire1_ff <= CTRL1_RESET[`PDIS_TWOWIRE1_BIT];
    end else if (wr_lane0) begin
      twowire1_ff <= nxt_ctrl[`PDIS_TWOWIRE1_BIT]; // [R2] [R8]
    end
  end

  // Second asynchronous port disable
  // Held until the next low-lane write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async2_ff <= CTRL1_RESET[`PDIS_ASYNC2_BIT];
    end else if (wr_lane0) begin
      async2_ff <= nxt_ctrl[`PDIS_ASYNC2_BIT]; // [R3] [R8]
    end
  end

  // First asynchronous port disable
  // Held until the next low-lane write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async1_ff <= CTRL1_RESET[`PDIS_ASYNC1_BIT];
    end else if (wr_lane0) begin
      async1_ff <= nxt_ctrl[`PDIS_ASYNC1_BIT]; // [R4] [R8]
    end
  end

  // Second synchronous port disable
  // Held until the next low-lane write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync2_ff <= CTRL1_RESET[`PDIS_SYNC2_BIT];
    end else if (wr_lane0) begin
      sync2_ff <= nxt_ctrl[`PDIS_SYNC2_BIT]; // [R5] [R8]
    end
  end

  // First synchronous port disable
  // Held until the next low-lane write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= CTRL1_RESET[`PDIS_SYNC1_BIT];
    end else if (wr_lane0) begin
      sync1_ff <= nxt_ctrl[`PDIS_SYNC1_BIT]; // [R6] [R8]
    end
  end

  // Bus controller disable, plain storage here
  // Its peripheral is outside this block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      can1_ff <= CTRL1_RESET[`PDIS_CAN1_BIT];
    end else if (wr_lane0) begin
      can1_ff <= nxt_ctrl[`PDIS_CAN1_BIT];
    end
  end

  // Converter disable; also steers the pin override below
  // Held until the next low-lane write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc1_ff <= CTRL1_RESET[`PDIS_ADC1_BIT];
    end else if (wr_lane0) begin
      adc1_ff <= nxt_ctrl[`PDIS_ADC1_BIT];
    end
  end

  // Zero wait: ready rises at the setup edge so access ends at once
  // Costs a flop per answer but keeps every output registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= setup_phase;
    end
  end

  // Error answer for any unmapped word, raised together with ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= setup_phase & ~hit;
    end
  end

  // Read data captured in setup; unmapped reads and writes return zero
  // Data then holds until the next setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= `PDIS_RD_IDLE;
    end else if (rd_setup) begin
      prdata_ff <= read_word(cur_ctrl); // [R1]
    end else if (setup_phase) begin
      prdata_ff <= `PDIS_RD_IDLE;
    end
  end

  // Converter off overrides the pin configuration
  // Pins lag the register by one edge; software must allow for it
  always_comb begin
    nxt_pin_digital = analog_pin_config_bits;
    if (adc1_ff) begin
      nxt_pin_digital = `PDIS_AN_ALL_DIGITAL; // [R7]
    end
  end

  // All digital during reset, so no pin floats as analog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_digital_ff <= `PDIS_AN_ALL_DIGITAL;
    end else begin
      pin_digital_ff <= nxt_pin_digital; // [R7]
    end
  end

  // Disables are the stored bits themselves, no extra stage
  assign twowire1_disable    = twowire1_ff; // [R2] [R8]
  assign async_port2_disable = async2_ff;   // [R3] [R8]
  assign async_port1_disable = async1_ff;   // [R4] [R8]
  assign sync_port2_disable  = sync2_ff;    // [R5] [R8]
  assign sync_port1_disable  = sync1_ff;    // [R6] [R8]

  // Disables for peripherals outside this block
  assign timer_disable       = timer_dis_ff;
  assign can1_disable        = can1_ff;
  assign adc1_disable        = adc1_ff;

  // Pin override
  assign analog_pin_digital  = pin_digital_ff;

  // Bus answers
  assign pready              = pready_ff;
  assign pslverr             = pslverr_ff;
  assign prdata              = prdata_ff;

endmodule // peripheral_disable_low_bits

// File: verif/pdis_chk.sv
`timescale 1ns/100ps
module pdis_chk
  import pdis_pkg::*;
(
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, adc1_disable,
  input wire apb_addr_t   paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0]  pstrb,
  input wire logic        twowire1_disable, async_port2_disable, async_port1_disable,
  input wire logic        sync_port2_disable, sync_port1_disable,
  input wire an_cfg_t     analog_pin_digital
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       wr = psel && penable && pready && pwrite && paddr == 12'h000 && pstrb[0];
  wire [4:0] dis = {twowire1_disable, async_port2_disable, async_port1_disable,
                    sync_port2_disable, sync_port1_disable};
  a_twowire_store: assert property (wr |=> twowire1_disable == $past(pwdata[7]))
    else $error("bit 7 store");
  a_async2_store: assert property (wr |=> async_port2_disable == $past(pwdata[6]))
    else $error("bit 6 store");
  a_async1_store: assert property (wr |=> async_port1_disable == $past(pwdata[5]))
    else $error("bit 5 store");
  a_sync2_store: assert property (wr |=> sync_port2_disable == $past(pwdata[4]))
    else $error("bit 4 store");
  a_sync1_store: assert property (wr |=> sync_port1_disable == $past(pwdata[3]))
    else $error("bit 3 store");
  a_gap_reads_zero: assert property (pready && !pwrite |-> prdata[10:8] == 3'h0)
    else $error("bits 10:8 not zero");
  a_pins_digital: assert property (adc1_disable |=> &analog_pin_digital)
    else $error("pins not digital");
  a_dis_hold_idle: assert property (!wr |=> $stable(dis))
    else $error("disable moved without write");
  c_write: cover property (wr);
  c_read: cover property (pready && !pwrite);
  c_adc_off: cover property (adc1_disable);
endmodule // pdis_chk
bind peripheral_disable_low_bits pdis_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .pready, .adc1_disable, .paddr, .pwdata, .prdata, .pstrb, .twowire1_disable,
  .async_port2_disable, .async_port1_disable, .sync_port2_disable, .sync_port1_disable,
  .analog_pin_digital);

// File: verif/tb.sv
`timescale 1ns/100ps
`include "pdis_consts.svh"
module tb;
  import pdis_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, se;
  logic twowire1_disable, async_port2_disable, async_port1_disable, adc1_disable;
  logic sync_port2_disable, sync_port1_disable, can1_disable;
  logic [4:0] timer_disable;
  apb_addr_t paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, r = 32'h93EA01B2;
  logic [3:0] pstrb = '0;
  logic [15:0] m = '0;
  an_cfg_t analog_pin_config_bits = '0, analog_pin_digital;
  int err_total = 0, n_checks = 0, cyc = 0;
  peripheral_disable_low_bits u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .twowire1_disable, .async_port2_disable,
    .async_port1_disable, .sync_port2_disable, .sync_port1_disable, .timer_disable,
    .can1_disable, .adc1_disable, .analog_pin_config_bits, .analog_pin_digital);
  initial forever #4 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, exp, got);
    end
  endtask
  task xfer(input logic w, input apb_addr_t a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; se = pslverr; psel <= 1'b0; penable <= 1'b0;
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      final_report;
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      r = lfsr(r); analog_pin_config_bits <= r; r = lfsr(r);
      // Index 7 goes to an unmapped word and must leave the register alone
      xfer(1'b1, (i == 7) ? 12'h004 : 12'h000, r, r[19:16]);
      if (i != 7 && r[16]) m[7:0] = r[7:0];
      if (i != 7 && r[17]) m[15:8] = r[15:8];
      m = m & `PDIS_CTRL1_MASK;
      chk("slverr", se, i == 7);
      repeat (2) @(posedge pclk);
      chk("disables", {twowire1_disable, async_port2_disable, async_port1_disable,
        sync_port2_disable, sync_port1_disable}, m[7:3]);
      chk("pins", analog_pin_digital,
        m[0] ? `PDIS_AN_ALL_DIGITAL : analog_pin_config_bits);
      if (i == 7) begin
        xfer(1'b0, 12'h004, '0, 4'h0);
        chk("unmapped read", rd, 32'h00000000);
        chk("unmapped read slverr", se, 1'b1);
      end
      xfer(1'b0, 12'h000, '0, 4'h0);
      chk("read slverr", se, 1'b0);
      chk("readback", rd, m);
    end
    final_report;
  end
endmodule // tb
